// ### inc/sos_pkg.sv
// constants shared by the status output selector
package sos_pkg;

	// ========================================================
	// register map (byte addresses, one word each)
	localparam int              NUM_TERM   = 5;
	localparam logic [7:0]      REG_SEL0   = 8'h00;   // selection codes at 0x00..0x10
	localparam logic [7:0]      REG_DETECT = 8'h14;
	localparam logic [7:0]      REG_WARN   = 8'h18;
	localparam logic [7:0]      REG_CFG    = 8'h1C;
	localparam logic [7:0]      REG_STATUS = 8'h20;

	// ========================================================
	// config register fields
	localparam int              CFG_RESTART_LSB = 0;  // restart_mode_setting, 3 bits
	localparam int              CFG_HWOC_BIT    = 3;  // hw_overcurrent_limit_enable
	localparam int              CFG_DECEL_LSB   = 4;  // auto_decel_setting, 3 bits
	localparam int              CFG_W           = 7;
	localparam logic [2:0]      RESTART_LO      = 3'h3;
	localparam logic [2:0]      RESTART_HI      = 3'h5;
	localparam logic [2:0]      DECEL_LIMITING  = 3'h3;

	// ========================================================
	// selection codes
	localparam logic [10:0]     POL_OFFSET   = 11'h3E8;   // 1000: inverted variant
	localparam logic [10:0]     CODE_RUN     = 11'h000;
	localparam logic [10:0]     CODE_ARRIVE  = 11'h001;
	localparam logic [10:0]     CODE_DETECT  = 11'h002;
	localparam logic [10:0]     CODE_UV      = 11'h003;
	localparam logic [10:0]     CODE_LIMIT   = 11'h005;
	localparam logic [10:0]     CODE_PFR     = 11'h006;
	localparam logic [10:0]     CODE_OLW     = 11'h007;
	localparam logic [10:0]     CODE_READY   = 11'h00A;
	localparam logic [10:0]     CODE_SW_LINE = 11'h00B;
	localparam logic [10:0]     CODE_SW_OUT  = 11'h00C;
	localparam logic [10:0]     CODE_SW_IN   = 11'h00D;
	localparam logic [10:0]     CODE_SUPPLY  = 11'h00F;
	localparam logic [10:0]     CODE_CURDET  = 11'h025;
	localparam logic [10:0]     CODE_MOUNT0  = 11'h03C;   // 60..65, then 67
	localparam logic [10:0]     CODE_M4_LINE = 11'h043;
	localparam logic [10:0]     CODE_PSWARN  = 11'h044;
	localparam logic [10:0]     CODE_ALARM   = 11'h063;

	// ========================================================
	// reset values
	localparam logic [10:0]     SEL_RST_TR   = 11'h000;   // transistor/Y5 terminals
	localparam logic [10:0]     SEL_RST_LAST = 11'h063;   // relay terminal: alarm
	localparam logic [15:0]     LVL_RST      = 16'h0000;

	// ========================================================
	// frequency comparators, 0.1 Hz per lsb
	localparam logic [15:0]     ARRIVE_TOL   = 16'h0019;  // 2.5 Hz
	localparam logic [15:0]     DETECT_HYST  = 16'h000A;  // 1 Hz

	// ========================================================
	// minimum on-time of the limiting indication
	localparam int              CLK_HZ       = 100000000;
	localparam int              LIMIT_MIN_MS = 100;
	localparam int              LIMIT_MIN_CYC = (CLK_HZ / 1000) * LIMIT_MIN_MS;

endpackage

// ### core/sos_hold.sv
// minimum-width stretcher for a level indication
module sos_hold #(
	parameter int MIN_CYC = sos_pkg::LIMIT_MIN_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic level_in,
	output logic      held_out
);
	import sos_pkg::*;

	localparam int CW = $clog2(MIN_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          out;
	} sos_hold_st_t;

	sos_hold_st_t s_q;
	sos_hold_st_t s_d;

	// ========================================================
	// restart the window on every active cycle, drop when both done
	always_comb begin
		s_d = s_q;
		if (level_in) begin
			s_d.out = 1'b1;
			s_d.cnt = CW'(MIN_CYC - 1);
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end else begin
			s_d.out = 1'b0;
		end
	end

	// counter runs off the system clock
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign held_out = s_q.out;
endmodule

// ### core/sos_core.sv
// status output selector: flag generation, terminal mapping, AHB-Lite registers
//
// Behaviour
// - code plus 1000 inverts the selected condition
// - codes 60-65 and 67 show pump motor mounting
// - contactor codes 11-13 refuse inverted polarity
// - running: above start, below stop, braking
// - arrival within 2.5 Hz of reference
// - detect above level, 1 Hz release hysteresis
// - undervoltage follows bus level and trip
// - run command ignored during undervoltage
// - limiting indication held at least 100 ms
// - limiting sources: software, hardware, auto-decel
// - restart flag: ride-through or until arrival
// - restart flag only for modes 3-5
// - warning level drives overload and current-detect
// - ready: preparation done, no protection active
// - codes 11-13 on transistor terminals enable changeover
// - supply contactor: on at run, off at standstill
// - supply contactor drops at coast or alarm
// - relay alarm normal polarity energises, default active-high
// - alarm selection follows any protective trip
//
// The implementer's own choices: register access over AHB-Lite and the address map.
module sos_core #(
	parameter int FW        = 16,
	parameter int LIMIT_CYC = sos_pkg::LIMIT_MIN_CYC
) (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// AHB-Lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic [31:0]        hrdata,
	// drive measurements and events
	input  wire logic [FW-1:0] out_freq,
	input  wire logic [FW-1:0] ref_freq,
	input  wire logic [FW-1:0] start_freq,
	input  wire logic [FW-1:0] stop_freq,
	input  wire logic          dc_brake,
	input  wire logic [FW-1:0] dc_bus_volt,
	input  wire logic [FW-1:0] uv_threshold,
	input  wire logic          uv_trip,
	input  wire logic [FW-1:0] out_current,
	input  wire logic          sw_limit_active,
	input  wire logic          hw_oc_active,
	input  wire logic          auto_decel_active,
	input  wire logic          momentary_pf_run,
	input  wire logic          uv_shutdown,
	input  wire logic          prep_done,
	input  wire logic          any_alarm,
	input  wire logic          fwd_cmd,
	input  wire logic          coast_cmd,
	input  wire logic          changeover_req,
	input  wire logic [6:0]    mount_status,
	input  wire logic          periodic_switch_warning,
	// outputs
	output logic [sos_pkg::NUM_TERM-1:0] term_out,
	output logic               run_enable,
	output logic               line_contactor_ctl,
	output logic               drive_input_contactor_ctl,
	output logic               drive_output_contactor_ctl
);
	import sos_pkg::*;

	typedef struct packed {
		logic [NUM_TERM-1:0][10:0] sel;
		logic [FW-1:0]             detect_level_setting;
		logic [FW-1:0]             warning_current_level;
		logic [CFG_W-1:0]          cfg;
		logic                      wr_pend;
		logic [7:0]                wr_addr;
		logic [31:0]               rdata;
		logic                      run;
		logic                      freq_arrival;
		logic                      freq_detect;
		logic                      undervoltage_flag;
		logic                      pf_pend;
		logic                      supply_contactor_ctl;
		logic                      run_en;
		logic                      line_ctl;
		logic                      din_ctl;
		logic                      dout_ctl;
		logic [NUM_TERM-1:0]       term;
		logic                      bus_rdy;
	} sos_st_t;

	sos_st_t s_q;
	sos_st_t s_d;

	logic          output_limiting;
	logic          limit_src;
	logic          power_fail_restart;
	logic          overload_warning;
	logic          current_detected;
	logic          ready;
	logic          changeover_en;
	logic [FW-1:0] freq_diff;
	logic [2:0]    restart_mode_setting;
	logic [15:0]   flag_vec;

	// ========================================================
	// limiting sources and their minimum width
	assign restart_mode_setting = s_q.cfg[CFG_RESTART_LSB +: 3];
	assign limit_src = sw_limit_active
		| (hw_oc_active & s_q.cfg[CFG_HWOC_BIT])
		| (auto_decel_active & (s_q.cfg[CFG_DECEL_LSB +: 3] == DECEL_LIMITING));

	sos_hold #(
		.MIN_CYC (LIMIT_CYC)
	) u_limit_hold (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.level_in (limit_src),
		.held_out (output_limiting)
	);

	// ========================================================
	// combinational flags
	assign freq_diff = (out_freq > ref_freq) ? (out_freq - ref_freq) : (ref_freq - out_freq);
	assign power_fail_restart = (restart_mode_setting >= RESTART_LO)
		&& (restart_mode_setting <= RESTART_HI)
		&& (momentary_pf_run || s_q.pf_pend);
	assign overload_warning = out_current > s_q.warning_current_level;
	assign current_detected = overload_warning;
	assign ready = prep_done & ~any_alarm;
	assign flag_vec = {6'h00, s_q.supply_contactor_ctl, any_alarm, ready, overload_warning,
		power_fail_restart, output_limiting, s_q.undervoltage_flag, s_q.freq_detect,
		s_q.freq_arrival, s_q.run};

	// changeover only when all three contactor codes sit on transistor terminals
	always_comb begin
		logic [2:0] seen;
		seen = 3'h0;
		for (int t = 0; t < 3; t++) begin
			if (s_q.sel[t] == CODE_SW_LINE) seen[0] = 1'b1;
			if (s_q.sel[t] == CODE_SW_OUT)  seen[1] = 1'b1;
			if (s_q.sel[t] == CODE_SW_IN)   seen[2] = 1'b1;
		end
		changeover_en = &seen;
	end

	// ========================================================
	// condition picked by a base code (polarity already removed)
	function automatic logic pick(input logic [10:0] base, input sos_st_t st,
		input logic lim, input logic pfr, input logic olw, input logic cdet, input logic rdy);
		logic c;
		c = 1'b0;
		case (base)
			CODE_RUN:     c = st.run;
			CODE_ARRIVE:  c = st.freq_arrival;
			CODE_DETECT:  c = st.freq_detect;
			CODE_UV:      c = st.undervoltage_flag;
			CODE_LIMIT:   c = lim;
			CODE_PFR:     c = pfr;
			CODE_OLW:     c = olw;
			CODE_READY:   c = rdy;
			CODE_SW_LINE: c = st.line_ctl;
			CODE_SW_OUT:  c = st.dout_ctl;
			CODE_SW_IN:   c = st.din_ctl;
			CODE_SUPPLY:  c = st.supply_contactor_ctl;
			CODE_CURDET:  c = cdet;
			CODE_PSWARN:  c = periodic_switch_warning;
			CODE_ALARM:   c = any_alarm;
			default: begin
				// unlisted codes read inactive; 66 has no motor
				if (base >= CODE_MOUNT0 && base <= CODE_M4_LINE && base != 11'h042) begin
					c = (base == CODE_M4_LINE) ? mount_status[6] : mount_status[3'(base - CODE_MOUNT0)];
				end
			end
		endcase
		return c;
	endfunction

	// register read view of a state copy
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input sos_st_t st, input logic [15:0] fv);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a < REG_DETECT && a[1:0] == 2'h0) begin
			r[10:0] = st.sel[a[4:2]];
		end else begin
			case (a)
				REG_DETECT: r[FW-1:0] = st.detect_level_setting;
				REG_WARN:   r[FW-1:0] = st.warning_current_level;
				REG_CFG:    r[CFG_W-1:0] = st.cfg;
				REG_STATUS: r[15:0] = fv;
				default:    r = 32'h0000_0000;
			endcase
		end
		return r;
	endfunction

	// ========================================================
	// next-state logic
	always_comb begin
		logic [10:0] wcode;
		logic [10:0] base;
		logic        inv;
		logic        cond;
		s_d = s_q;
		wcode = hwdata[10:0];
		base = 11'h000;
		inv = 1'b0;
		cond = 1'b0;

		// zero wait states; ready is low only up to the first edge after reset
		s_d.bus_rdy = 1'b1;

		// write data phase: store into the decoded register
		s_d.wr_pend = 1'b0;
		if (s_q.wr_pend) begin
			if (s_q.wr_addr < REG_DETECT && s_q.wr_addr[1:0] == 2'h0) begin
				// inverted contactor codes are refused, old code kept
				if (!(wcode >= CODE_SW_LINE + POL_OFFSET && wcode <= CODE_SW_IN + POL_OFFSET)) begin
					s_d.sel[s_q.wr_addr[4:2]] = wcode;
				end
			end else begin
				case (s_q.wr_addr)
					REG_DETECT: s_d.detect_level_setting = hwdata[FW-1:0];
					REG_WARN:   s_d.warning_current_level = hwdata[FW-1:0];
					REG_CFG:    s_d.cfg = hwdata[CFG_W-1:0];
					default:    s_d.cfg = s_q.cfg;
				endcase
			end
		end

		// address phase; read data comes from the updated copy so a read
		// right after a write sees the new value
		if (hsel && hready && htrans[1]) begin
			s_d.wr_pend = hwrite;
			s_d.wr_addr = haddr[7:0];
			if (!hwrite) begin
				s_d.rdata = rd_mux(haddr[7:0], s_d, flag_vec);
			end
		end

		// running: start above start freq, stop below stop freq
		if (dc_brake) begin
			s_d.run = 1'b0;
		end else if (out_freq > start_freq) begin
			s_d.run = 1'b1;
		end else if (out_freq < stop_freq) begin
			s_d.run = 1'b0;
		end

		s_d.freq_arrival = freq_diff <= ARRIVE_TOL;

		// detect with fixed release band; guarded against underflow near zero
		if (out_freq > s_q.detect_level_setting) begin
			s_d.freq_detect = 1'b1;
		end else if (s_q.detect_level_setting >= DETECT_HYST
			&& out_freq < s_q.detect_level_setting - DETECT_HYST) begin
			s_d.freq_detect = 1'b0;
		end

		// undervoltage: trip forces it, otherwise follows the bus
		if (uv_trip || dc_bus_volt < uv_threshold) begin
			s_d.undervoltage_flag = 1'b1;
		end else if (dc_bus_volt > uv_threshold) begin
			s_d.undervoltage_flag = 1'b0;
		end

		s_d.run_en = fwd_cmd & ~s_q.undervoltage_flag;

		// pending restart set at shutdown (wins over clear), ends at arrival
		if (uv_shutdown) begin
			s_d.pf_pend = 1'b1;
		end else if (s_q.freq_arrival && s_q.run) begin
			s_d.pf_pend = 1'b0;
		end

		// supply contactor
		if (coast_cmd || any_alarm) begin
			s_d.supply_contactor_ctl = 1'b0;
		end else if (fwd_cmd) begin
			s_d.supply_contactor_ctl = 1'b1;
		end else if (out_freq == '0) begin
			s_d.supply_contactor_ctl = 1'b0;
		end

		// changeover contactors; line and drive sides never on together
		s_d.line_ctl = changeover_en & ~changeover_req & fwd_cmd;
		s_d.din_ctl = changeover_en & changeover_req;
		s_d.dout_ctl = changeover_en & changeover_req;

		// terminal mapping
		for (int t = 0; t < NUM_TERM; t++) begin
			inv = s_q.sel[t] >= POL_OFFSET;
			base = inv ? s_q.sel[t] - POL_OFFSET : s_q.sel[t];
			cond = pick(base, s_q, output_limiting, power_fail_restart, overload_warning,
				current_detected, ready);
			s_d.term[t] = cond ^ inv;
		end
	end

	// ========================================================
	// state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			for (int t = 0; t < NUM_TERM - 1; t++) begin
				s_q.sel[t] <= SEL_RST_TR;
			end
			s_q.sel[NUM_TERM-1] <= SEL_RST_LAST;
			s_q.detect_level_setting <= LVL_RST[FW-1:0];
			s_q.warning_current_level <= LVL_RST[FW-1:0];
		end else begin
			s_q <= s_d;
		end
	end

	// zero-wait slave, always OKAY
	assign hreadyout = s_q.bus_rdy;
	assign hresp = 1'b0;
	assign hrdata = s_q.rdata;
	assign term_out = s_q.term;
	assign run_enable = s_q.run_en;
	assign line_contactor_ctl = s_q.line_ctl;
	assign drive_input_contactor_ctl = s_q.din_ctl;
	assign drive_output_contactor_ctl = s_q.dout_ctl;
endmodule

// ### testbench/sos_properties.sv
// concurrent checks on the status output selector ports
module sos_properties
	import sos_pkg::*;
#(
	parameter int FW        = 16,
	parameter int LIMIT_CYC = 20
) (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	input  wire logic [31:0]   hrdata,
	input  wire logic [FW-1:0] out_freq,
	input  wire logic [FW-1:0] start_freq,
	input  wire logic          dc_brake,
	input  wire logic          uv_trip,
	input  wire logic          any_alarm,
	input  wire logic          fwd_cmd,
	input  wire logic          coast_cmd,
	input  wire logic [4:0]    term_out,
	input  wire logic          run_enable
);
	// ==========
	// shadow of terminal 0 selection; refused contactor inversions leave it alone
	logic        wr_q;
	logic        rd_q;
	logic [7:0]  a_q;
	logic [10:0] sel0_q;
	logic [31:0] hi_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			a_q    <= 8'h00;
			sel0_q <= SEL_RST_TR;
			hi_q   <= 32'h0;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			rd_q <= hsel && hready && htrans[1] && !hwrite;
			a_q  <= haddr[7:0];
			hi_q <= term_out[0] ? hi_q + 32'h1 : 32'h0;
			if (wr_q && a_q == REG_SEL0 && !(hwdata[10:0] inside {11'h3F3, 11'h3F4, 11'h3F5})) begin
				sel0_q <= hwdata[10:0];
			end
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// limiting pin dropping while the selection stayed put
	sequence lim_fall_s;
		sel0_q == CODE_LIMIT && $past(sel0_q) == CODE_LIMIT && $past(sel0_q, 2) == CODE_LIMIT && $fell(term_out[0]);
	endsequence

	// ==========
	// properties; the two-cycle pin latency is covered by three-cycle antecedents
	run_on_a: assert property ((sel0_q == CODE_RUN && out_freq > start_freq && !dc_brake) [*3] |-> term_out[0])
		else $error("run indication missing above start frequency");
	brake_off_a: assert property ((sel0_q == CODE_RUN && dc_brake) [*3] |-> !term_out[0])
		else $error("run indication high during braking");
	invert_pol_a: assert property ((sel0_q == POL_OFFSET && dc_brake) [*3] |-> term_out[0])
		else $error("inverted run indication not high when stopped");
	supply_drop_a: assert property ((sel0_q == CODE_SUPPLY && (coast_cmd || any_alarm)) [*3] |-> !term_out[0])
		else $error("supply contactor held on coast or alarm");
	alarm_sel_a: assert property ((sel0_q == CODE_ALARM && any_alarm) [*3] |-> term_out[0])
		else $error("alarm selection not following alarm");
	limit_width_a: assert property (lim_fall_s |-> hi_q >= LIMIT_CYC)
		else $error("limiting indication shorter than minimum width");
	uv_block_a: assert property (uv_trip [*3] |-> !run_enable)
		else $error("run enabled during undervoltage trip");
	fwd_need_a: assert property (!fwd_cmd [*3] |-> !run_enable)
		else $error("run enabled without run command");
	sel_readback_a: assert property (rd_q && a_q == REG_SEL0 |-> hrdata[10:0] == sel0_q)
		else $error("selection readback differs from accepted writes");
endmodule

bind sos_core sos_properties #(.FW(FW), .LIMIT_CYC(LIMIT_CYC)) sos_properties_i (
	.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .out_freq, .start_freq,
	.dc_brake, .uv_trip, .any_alarm, .fwd_cmd, .coast_cmd, .term_out, .run_enable);

// ### testbench/sos_ext_equip.sv
// model of the external equipment reading the output terminals
module sos_ext_equip (
	input  wire logic       clk_sys,
	input  wire logic [4:0] term_out,
	output logic      [4:0] seen
);
	// ==========
	// input stage of the equipment: terminals latched once per clock
	always_ff @(posedge clk_sys) begin
		seen <= term_out;
	end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the status output selector
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import sos_pkg::*;
	localparam int LIM = 20;
	logic        clk_sys, rst, hsel, hwrite, hreadyout, dc_brake, uv_trip, sw_limit_active, hw_oc_active;
	logic        auto_decel_active, momentary_pf_run, uv_shutdown, prep_done, any_alarm, fwd_cmd, coast_cmd;
	logic        changeover_req, periodic_switch_warning, run_enable;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [6:0]  mount_status;
	logic [4:0]  term_out, seen;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [15:0] out_freq, ref_freq, start_freq, stop_freq, dc_bus_volt, uv_threshold, out_current;
	int          mismatches, checks_done;
	logic        line_contactor_ctl, drive_input_contactor_ctl, drive_output_contactor_ctl;
	wire         hready = hreadyout;
	wire  [2:0]  ctl = {line_contactor_ctl, drive_input_contactor_ctl, drive_output_contactor_ctl};

	sos_core #(.LIMIT_CYC(LIM)) sos_core_i (
		.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp(), .hrdata,
		.out_freq, .ref_freq, .start_freq, .stop_freq, .dc_brake, .dc_bus_volt, .uv_threshold, .uv_trip,
		.out_current, .sw_limit_active, .hw_oc_active, .auto_decel_active, .momentary_pf_run, .uv_shutdown,
		.prep_done, .any_alarm, .fwd_cmd, .coast_cmd, .changeover_req, .mount_status, .periodic_switch_warning,
		.term_out, .run_enable, .line_contactor_ctl, .drive_input_contactor_ctl, .drive_output_contactor_ctl);
	sos_ext_equip sos_ext_equip_i (.clk_sys, .term_out, .seen);

	// ==========
	// comparison, bus and timing helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
		end
	endtask
	task automatic chkb(input logic got, input logic want);
		chk({31'h0, got}, {31'h0, want});
	endtask
	// address phase held until hready, then data phase until hready again
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wsel(input logic [10:0] code);
		bus(1'b1, REG_SEL0, {21'h0, code});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// status bit read through the bus; settles the flags first
	task automatic stat(input logic [31:0] m, input logic want);
		cyc(3);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(rd & m, want ? m : 32'h0);
	endtask

	// ==========
	// scenarios
	task automatic test_reset;
		bus(1'b0, REG_SEL0 + 8'h10, 32'h0);
		chk(rd, {21'h0, SEL_RST_LAST});
		bus(1'b0, REG_SEL0, 32'h0);
		chk(rd, {21'h0, SEL_RST_TR});
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		stat(32'h80, 1'b1);
		$display("test reset done");
	endtask
	task automatic test_polarity;
		@(posedge clk_sys) out_freq <= 16'h012C;
		cyc(4);
		chkb(term_out[0], 1'b1);
		chkb(seen[0], 1'b1);
		wsel(POL_OFFSET);
		cyc(4);
		chkb(term_out[0], 1'b0);
		@(posedge clk_sys) dc_brake <= 1'b1;
		cyc(4);
		chkb(term_out[0], 1'b1);
		wsel(CODE_RUN);
		@(posedge clk_sys) dc_brake <= 1'b0;
		@(posedge clk_sys) out_freq <= 16'h0005;
		cyc(4);
		chkb(term_out[0], 1'b0);
		@(posedge clk_sys) mount_status <= 7'h40;
		wsel(CODE_M4_LINE);
		cyc(4);
		chkb(term_out[0], 1'b1);
		wsel(POL_OFFSET + CODE_M4_LINE);
		cyc(4);
		chkb(term_out[0], 1'b0);
		$display("test polarity done");
	endtask
	task automatic test_refuse;
		wsel(CODE_SW_LINE);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, REG_SEL0, 32'h3F3 + i);
			bus(1'b0, REG_SEL0, 32'h0);
			chk(rd, {21'h0, CODE_SW_LINE});
		end
		$display("test refuse done");
	endtask
	task automatic test_uv;
		@(posedge clk_sys) fwd_cmd <= 1'b1;
		cyc(4);
		chkb(run_enable, 1'b1);
		@(posedge clk_sys) dc_bus_volt <= 16'h00C8;
		cyc(4);
		chkb(run_enable, 1'b0);
		stat(32'h8, 1'b1);
		@(posedge clk_sys) {uv_trip, dc_bus_volt} <= {1'b1, 16'h01F4};
		stat(32'h8, 1'b1);
		@(posedge clk_sys) uv_trip <= 1'b0;
		stat(32'h8, 1'b0);
		chkb(run_enable, 1'b1);
		@(posedge clk_sys) fwd_cmd <= 1'b0;
		$display("test undervoltage done");
	endtask
	task automatic test_limit;
		wsel(CODE_LIMIT);
		bus(1'b1, REG_CFG, 32'h38);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys) {auto_decel_active, hw_oc_active, sw_limit_active} <= 3'h1 << i;
			@(posedge clk_sys) {auto_decel_active, hw_oc_active, sw_limit_active} <= 3'h0;
			cyc(3);
			chkb(term_out[0], 1'b1);
			cyc(LIM - 6);
			chkb(term_out[0], 1'b1);
			cyc(8);
			chkb(term_out[0], 1'b0);
		end
		bus(1'b1, REG_CFG, 32'h0);
		@(posedge clk_sys) hw_oc_active <= 1'b1;
		cyc(4);
		chkb(term_out[0], 1'b0);
		@(posedge clk_sys) hw_oc_active <= 1'b0;
		$display("test limiting done");
	endtask
	task automatic test_supply;
		wsel(CODE_SUPPLY);
		@(posedge clk_sys) {fwd_cmd, out_freq} <= {1'b1, 16'h012C};
		cyc(4);
		chkb(term_out[0], 1'b1);
		@(posedge clk_sys) fwd_cmd <= 1'b0;
		cyc(4);
		chkb(term_out[0], 1'b1);
		@(posedge clk_sys) out_freq <= 16'h0000;
		cyc(4);
		chkb(term_out[0], 1'b0);
		@(posedge clk_sys) {fwd_cmd, out_freq, coast_cmd} <= {1'b1, 16'h012C, 1'b1};
		cyc(4);
		chkb(term_out[0], 1'b0);
		@(posedge clk_sys) {coast_cmd, any_alarm} <= 2'b01;
		cyc(4);
		chkb(term_out[0], 1'b0);
		wsel(CODE_ALARM);
		cyc(4);
		chkb(term_out[0], 1'b1);
		chkb(term_out[4], 1'b1);
		stat(32'h80, 1'b0);
		bus(1'b1, REG_SEL0 + 8'h10, {21'h0, POL_OFFSET + CODE_ALARM});
		cyc(4);
		chkb(term_out[4], 1'b0);
		@(posedge clk_sys) {any_alarm, fwd_cmd} <= 2'b00;
		$display("test supply done");
	endtask
	task automatic test_flags;
		@(posedge clk_sys) momentary_pf_run <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			bus(1'b1, REG_CFG, m);
			stat(32'h20, m >= 3 && m <= 5);
		end
		@(posedge clk_sys) {momentary_pf_run, ref_freq, out_freq} <= {1'b0, 16'h01F4, 16'h020D};
		stat(32'h2, 1'b1);
		@(posedge clk_sys) out_freq <= 16'h020E;
		stat(32'h2, 1'b0);
		bus(1'b1, REG_DETECT, 32'h64);
		@(posedge clk_sys) out_freq <= 16'h0065;
		stat(32'h4, 1'b1);
		@(posedge clk_sys) out_freq <= 16'h005F;
		stat(32'h4, 1'b1);
		@(posedge clk_sys) out_freq <= 16'h0059;
		stat(32'h4, 1'b0);
		bus(1'b1, REG_WARN, 32'h64);
		@(posedge clk_sys) out_current <= 16'h0096;
		stat(32'h40, 1'b1);
		wsel(CODE_CURDET);
		cyc(4);
		chkb(term_out[0], 1'b1);
		// pending restart: set by shutdown, held until arrival while running
		bus(1'b1, REG_CFG, 32'h4);
		@(posedge clk_sys) uv_shutdown <= 1'b1;
		@(posedge clk_sys) uv_shutdown <= 1'b0;
		stat(32'h20, 1'b1);
		@(posedge clk_sys) out_freq <= 16'h01F4;
		stat(32'h20, 1'b0);
		@(posedge clk_sys) periodic_switch_warning <= 1'b1;
		wsel(CODE_PSWARN);
		cyc(4);
		chkb(term_out[0], 1'b1);
		$display("test flags done");
	endtask
	// contactor codes on terminals 0..2 route the changeover outputs to the pins
	task automatic test_changeover;
		wsel(CODE_SW_LINE);
		bus(1'b1, REG_SEL0 + 8'h04, {21'h0, CODE_SW_OUT});
		bus(1'b1, REG_SEL0 + 8'h08, {21'h0, CODE_SW_IN});
		@(posedge clk_sys) {fwd_cmd, changeover_req} <= 2'b10;
		cyc(4);
		chk({29'h0, ctl}, 32'h4);
		chk({29'h0, term_out[2:0]}, 32'h1);
		@(posedge clk_sys) changeover_req <= 1'b1;
		cyc(4);
		chk({29'h0, ctl}, 32'h3);
		chk({29'h0, term_out[2:0]}, 32'h6);
		@(posedge clk_sys) {fwd_cmd, changeover_req} <= 2'b00;
		$display("test changeover done");
	endtask

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========
	// clock, watchdog and main sequence
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#100us;
		mismatches++;
		give_verdict();
	end
	initial begin
		{mismatches, checks_done} = '0;
		{rst, hsel, hwrite, dc_brake, uv_trip, sw_limit_active, hw_oc_active, auto_decel_active} = 8'h80;
		{momentary_pf_run, uv_shutdown, any_alarm, fwd_cmd, coast_cmd, changeover_req} = 6'h0;
		{prep_done, periodic_switch_warning, htrans, hsize, mount_status} = {1'b1, 1'b0, 2'h0, 3'h2, 7'h0};
		{haddr, hwdata, out_freq, ref_freq} = '0;
		{start_freq, stop_freq, dc_bus_volt, uv_threshold, out_current} = {16'h000A, 16'h0008, 16'h01F4, 16'h012C, 16'h0};
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		test_reset();
		test_polarity();
		test_refuse();
		test_uv();
		test_limit();
		test_supply();
		test_flags();
		test_changeover();
		give_verdict();
	end
endmodule
